// file: hdl/sqm_pkg.sv
// package: constants and carriers of the shared sram queue manager
package sqm_pkg;

  // ==========================================================================
  // sizes
  localparam int unsigned QUEUES = 64;
  localparam int unsigned FLAG_QUEUES = 32;
  localparam int unsigned SRAM_WORDS = 2048; // 8KB of 32-bit words

  // ==========================================================================
  // byte offsets on the register port
  localparam logic [13:0] OFS_QACC_END = 14'h0400; // queue access window ends here
  localparam logic [13:0] OFS_STAT = 14'h0400; // fill flags of queues 0-31, 4 words
  localparam logic [13:0] OFS_UOFLOW = 14'h0410; // underflow word, then overflow word
  localparam logic [13:0] OFS_LOW_FILL_HI = 14'h0418; // low-fill flags of queues 32-63
  localparam logic [13:0] OFS_FULL_HI = 14'h041C; // saturated flags of queues 32-63
  localparam logic [13:0] OFS_SRC_SEL = 14'h0420; // interrupt source selects, 4 words
  localparam logic [13:0] OFS_INT_EN = 14'h0430; // interrupt enables, 2 words
  localparam logic [13:0] OFS_INT_PEND = 14'h0438; // pending interrupts, 2 words
  localparam logic [13:0] OFS_SRAM = 14'h2000; // raw sram, config words first

  // ==========================================================================
  // reset values
  localparam logic [3:0] FLAGS_RST = 4'h3; // vacant and low-fill set

  // ==========================================================================
  // carriers
  typedef struct packed {
    logic full;
    logic high_fill;
    logic low_fill;
    logic empty;
  } flag_s;

  // queue configuration word as held in sram
  typedef struct packed {
    logic spare;
    logic [6:0] base;
    logic [2:0] high_fill_wm;
    logic [2:0] low_fill_wm;
    logic [1:0] qsize;
    logic [1:0] esize;
    logic [6:0] wp;
    logic [6:0] rp;
  } cfg_s;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [13:0] addr;
    logic [31:0] wdata;
  } reg_req_s;

  typedef flag_s [31:0] flag_bus_t;

  typedef struct packed {
    flag_s [63:0] flg;
    logic [31:0] uflow;
    logic [31:0] oflow;
    logic [63:0][1:0] seq;
    logic [31:0][3:0] src;
    logic [63:0] ien;
    logic [63:0] ipend;
    flag_s evt;
    logic irq_lo;
    logic irq_hi;
    logic [31:0] rdata;
  } qm_state_s;

endpackage

// file: hdl/sram_queue_manager.sv
// module: 64-queue circular buffer manager in an internal sram
`timescale 1ns/100ps
`default_nettype none

module sram_queue_manager (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic reset_i,
  // register port
  input wire sqm_pkg::reg_req_s reg_req_i,
  output logic [31:0] rd_data_o,
  // network engine side
  output var sqm_pkg::flag_bus_t flag_bus_o,
  output var sqm_pkg::flag_s event_bus_o,
  // processor interrupts
  output logic irq_lo_o,
  output logic irq_hi_o
);

  // ==========================================================================
  // helpers

  // log2 of the entry size in words; code 3 is taken as four words
  function automatic logic [1:0] ent_shift(input logic [1:0] code);
    return (code == 2'h3) ? 2'h2 : code;
  endfunction

  // active pointer bits for a queue size code
  function automatic logic [6:0] ptr_mask(input logic [1:0] code);
    logic [7:0] sz;
    sz = 8'(8'h10 << code);
    return 7'(sz - 8'h01);
  endfunction

  // watermark in entries: 0, 1, 2, 4 .. 64
  function automatic logic [7:0] wm_val(input logic [2:0] code);
    return (code == 3'h0) ? 8'h00 : 8'(8'h01 << 3'(code - 3'h1));
  endfunction

  // fill flags of a queue from its configuration word
  function automatic sqm_pkg::flag_s flags_of(input sqm_pkg::cfg_s c, input logic full_f, input logic empty_f);
    logic [6:0] m;
    logic [1:0] sh;
    logic [7:0] occ;
    logic [7:0] ents;
    logic [7:0] size_ents;
    sqm_pkg::flag_s f;
    m = ptr_mask(c.qsize);
    sh = ent_shift(c.esize);
    occ = full_f ? ({1'b0, m} + 8'h01) : {1'b0, 7'((c.wp - c.rp) & m)};
    ents = occ >> sh;
    size_ents = ({1'b0, m} + 8'h01) >> sh;
    f.empty = empty_f;
    f.full = full_f;
    f.low_fill = (ents <= wm_val(c.low_fill_wm));
    f.high_fill = (8'(size_ents - ents) <= wm_val(c.high_fill_wm));
    return f;
  endfunction

  // ==========================================================================
  // storage and state

  // one array holds config words and every queue buffer
  logic [31:0] mem [0:sqm_pkg::SRAM_WORDS-1];
  sqm_pkg::qm_state_s st_r;
  sqm_pkg::qm_state_s st_nxt;

  // ==========================================================================
  // access decode
  logic [13:0] a;
  logic acc;
  logic is_q;
  logic is_sram;
  logic is_cfg;
  logic [5:0] q;
  logic [4:0] q_lo;
  logic [1:0] w;
  logic [10:0] sidx;
  sqm_pkg::cfg_s cfg;
  logic [1:0] sh;
  logic [2:0] ew;
  logic [6:0] mask;
  logic [6:0] ptr;
  logic [6:0] ptr_adv;
  logic [10:0] didx;
  logic legal;
  logic last;

  assign a = reg_req_i.addr;
  assign acc = reg_req_i.wr || reg_req_i.rd;
  assign is_q = (a < sqm_pkg::OFS_QACC_END);
  assign is_sram = (a >= sqm_pkg::OFS_SRAM);
  assign sidx = a[12:2];
  assign is_cfg = is_sram && (sidx[10:6] == 5'h00);
  assign q = a[9:4];
  assign q_lo = a[8:4];
  assign w = a[3:2];
  // config word of the addressed queue, fetched in the same cycle
  assign cfg = sqm_pkg::cfg_s'(mem[{5'h00, q}]);
  assign sh = ent_shift(cfg.esize);
  assign ew = 3'(3'h1 << sh);
  assign mask = ptr_mask(cfg.qsize);
  assign ptr = reg_req_i.rd ? cfg.rp : cfg.wp;
  assign ptr_adv = 7'((ptr + {4'h0, ew}) & mask);
  // base sits on a 16-word boundary; pointer wraps inside the buffer
  assign didx = 11'({cfg.base, 4'h0} + {4'h0, 7'((ptr + {5'h00, w}) & mask)});
  assign legal = ({1'b0, w} < ew) && (w == st_r.seq[q]);
  assign last = ({1'b0, w} == 3'(ew - 3'h1));

  // ==========================================================================
  // sram write ports: data or raw word, and config write-back
  logic dwe;
  logic [10:0] da;
  logic [31:0] dd;
  logic cwe;
  sqm_pkg::cfg_s cd;

  // no reset on the array: software must program config words before use
  always_ff @(posedge ref_clk_i) begin
    if (dwe) begin
      mem[da] <= dd;
    end
    if (cwe) begin
      mem[{5'h00, q}] <= cd;
    end
  end

  // ==========================================================================
  // next-state logic
  always_comb begin
    sqm_pkg::cfg_s cfg_n;
    logic full_f;
    logic empty_f;
    logic [31:0] rd_n;
    logic [63:0] clr;
    logic [3:0] ov;
    logic [3:0] nv;
    logic [3:0] s;
    logic ev;
    logic [31:0] hi_low_fill;
    logic [31:0] hi_full;
    cfg_n = cfg;
    full_f = 1'b0;
    empty_f = 1'b0;
    rd_n = 32'h0000_0000;
    clr = 64'h0;
    ov = 4'h0;
    nv = 4'h0;
    s = 4'h0;
    ev = 1'b0;
    hi_low_fill = 32'h0;
    hi_full = 32'h0;
    st_nxt = st_r;
    dwe = 1'b0;
    da = 11'h000;
    dd = 32'h0000_0000;
    cwe = 1'b0;
    // unused pointer bits are cleared on every write-back
    cfg_n.rp = cfg.rp & mask;
    cfg_n.wp = cfg.wp & mask;
    cd = cfg_n;
    for (int i = 0; i < 32; i++) begin
      hi_low_fill[i] = st_r.flg[i + 32].low_fill;
      hi_full[i] = st_r.flg[i + 32].full;
    end

    if (acc && is_q) begin
      // queue access window: no storage, work on the pointed word
      if (!legal) begin
        st_nxt.seq[q] = 2'h0;
      end else if (reg_req_i.rd && st_r.flg[q].empty) begin
        if (!q[5]) begin
          st_nxt.uflow[q_lo] = 1'b1;
        end
      end else if (reg_req_i.wr && st_r.flg[q].full) begin
        if (!q[5]) begin
          st_nxt.oflow[q_lo] = 1'b1;
        end
      end else begin
        if (reg_req_i.rd) begin
          rd_n = mem[didx];
        end else begin
          dwe = 1'b1;
          da = didx;
          dd = reg_req_i.wdata;
        end
        if (last) begin
          // whole entry done: move the pointer and refresh the flags
          st_nxt.seq[q] = 2'h0;
          if (reg_req_i.rd) begin
            cfg_n.rp = ptr_adv;
            empty_f = (ptr_adv == cfg_n.wp);
          end else begin
            cfg_n.wp = ptr_adv;
            full_f = (ptr_adv == cfg_n.rp);
          end
          cwe = 1'b1;
          cd = cfg_n;
          st_nxt.flg[q] = flags_of(cfg_n, full_f, empty_f);
        end else begin
          st_nxt.seq[q] = 2'(st_r.seq[q] + 2'h1);
        end
      end
    end else if (acc && is_sram) begin
      // raw sram, config words included
      if (reg_req_i.rd) begin
        rd_n = mem[sidx];
      end else begin
        dwe = 1'b1;
        da = sidx;
        dd = reg_req_i.wdata;
        if (is_cfg) begin
          // a fresh config word restarts the queue's status
          st_nxt.flg[sidx[5:0]] = flags_of(sqm_pkg::cfg_s'(reg_req_i.wdata), 1'b0,
            reg_req_i.wdata[6:0] == reg_req_i.wdata[13:7]);
          st_nxt.seq[sidx[5:0]] = 2'h0;
        end
      end
    end else if (acc) begin
      // status and interrupt registers; unmapped reads give zero
      if (a[13:4] == sqm_pkg::OFS_STAT[13:4]) begin
        rd_n = st_r.flg[{a[3:2], 3'h0} +: 8];
      end else if (a[13:3] == sqm_pkg::OFS_UOFLOW[13:3]) begin
        rd_n = a[2] ? st_r.oflow : st_r.uflow;
        if (reg_req_i.wr && a[2]) begin
          st_nxt.oflow = st_r.oflow & ~reg_req_i.wdata;
        end else if (reg_req_i.wr) begin
          st_nxt.uflow = st_r.uflow & ~reg_req_i.wdata;
        end
      end else if (a == sqm_pkg::OFS_LOW_FILL_HI) begin
        rd_n = hi_low_fill;
      end else if (a == sqm_pkg::OFS_FULL_HI) begin
        rd_n = hi_full;
      end else if (a[13:4] == sqm_pkg::OFS_SRC_SEL[13:4]) begin
        rd_n = st_r.src[{a[3:2], 3'h0} +: 8];
        if (reg_req_i.wr) begin
          st_nxt.src[{a[3:2], 3'h0} +: 8] = reg_req_i.wdata;
        end
      end else if (a[13:3] == sqm_pkg::OFS_INT_EN[13:3]) begin
        rd_n = st_r.ien[{a[2], 5'h00} +: 32];
        if (reg_req_i.wr) begin
          st_nxt.ien[{a[2], 5'h00} +: 32] = reg_req_i.wdata;
        end
      end else if (a[13:3] == sqm_pkg::OFS_INT_PEND[13:3]) begin
        rd_n = st_r.ipend[{a[2], 5'h00} +: 32];
        if (reg_req_i.wr) begin
          clr[{a[2], 5'h00} +: 32] = reg_req_i.wdata;
        end
      end
    end
    // only the read cycle's follower carries data
    st_nxt.rdata = reg_req_i.rd ? rd_n : 32'h0000_0000;

    // flag edges feed the pending bits; a new event beats a clear
    for (int i = 0; i < 64; i++) begin
      ov = st_r.flg[i];
      nv = st_nxt.flg[i];
      if (i < 32) begin
        s = st_r.src[i];
        ev = s[2] ? (ov[s[1:0]] && !nv[s[1:0]]) : (!ov[s[1:0]] && nv[s[1:0]]);
      end else begin
        ev = !ov[1] && nv[1];
      end
      st_nxt.ipend[i] = (st_r.ipend[i] && !clr[i]) || ev;
    end
    // enables gate each queue onto its group line
    st_nxt.irq_lo = |(st_nxt.ipend[31:0] & st_nxt.ien[31:0]);
    st_nxt.irq_hi = |(st_nxt.ipend[63:32] & st_nxt.ien[63:32]);

    // upper queues as one or-combined group on the event bus
    st_nxt.evt = 4'h0;
    for (int i = 32; i < 64; i++) begin
      st_nxt.evt = st_nxt.evt | st_nxt.flg[i];
    end
  end

  // ==========================================================================
  // state register
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      st_r <= '0;
      st_r.flg <= {64{sqm_pkg::FLAGS_RST}};
      st_r.evt <= sqm_pkg::FLAGS_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ==========================================================================
  // outputs, all from the state register
  assign rd_data_o = st_r.rdata;
  assign flag_bus_o = st_r.flg[31:0];
  assign event_bus_o = st_r.evt;
  assign irq_lo_o = st_r.irq_lo;
  assign irq_hi_o = st_r.irq_hi;

  // ==========================================================================
  // checks
  AST_UNDERFLOW_ZERO: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    (reg_req_i.rd && is_q && legal && st_r.flg[q].empty) |=> (rd_data_o == 32'h0000_0000))
    else $error("read of empty queue returned data");

  AST_UNDERFLOW_FLAG: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    (reg_req_i.rd && is_q && !q[5] && legal && st_r.flg[q].empty) |=> st_r.uflow[$past(q_lo)])
    else $error("underflow flag not set");

  AST_OVERFLOW_HOLD: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    (reg_req_i.wr && is_q && st_r.flg[q].full) |-> (!dwe && !cwe))
    else $error("write to full queue touched sram");

  AST_OVERFLOW_FLAG: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    (reg_req_i.wr && is_q && !q[5] && legal && st_r.flg[q].full) |=> st_r.oflow[$past(q_lo)])
    else $error("overflow flag not set");

  AST_PTR_UNUSED_ZERO: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    cwe |-> (((cd.rp | cd.wp) & ~mask) == 7'h00))
    else $error("unused pointer bits written back");

  AST_ORDER_HOLD: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    (acc && is_q && !legal) |-> (!cwe && !dwe) ##1 (rd_data_o == 32'h0000_0000))
    else $error("out-of-order queue access was performed");

  AST_FLAGS_EXCL: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    (acc && is_q) |-> !(st_r.flg[q].empty && st_r.flg[q].full))
    else $error("queue both vacant and saturated");

  AST_IRQ_GATE: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    (irq_lo_o == |(st_r.ipend[31:0] & st_r.ien[31:0])) && (irq_hi_o == |(st_r.ipend[63:32] & st_r.ien[63:32])))
    else $error("interrupt output disagrees with enables");

  AST_RESET_QUIET: assert property (@(posedge ref_clk_i)
    reset_i |=> (!irq_lo_o && !irq_hi_o && (st_r.ien == 64'h0)))
    else $error("reset left interrupts live");

  AST_POP_ADVANCE: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    (reg_req_i.rd && is_q && legal && last && !st_r.flg[q].empty) |-> (cwe && (cd.rp == ptr_adv)))
    else $error("read pointer not advanced");

  AST_PUSH_ADVANCE: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    (reg_req_i.wr && is_q && legal && last && !st_r.flg[q].full) |-> (cwe && (cd.wp == ptr_adv)))
    else $error("write pointer not advanced");

  // read data must not linger past its one cycle
  AST_RDATA_ONE_CYCLE: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    !reg_req_i.rd |=> (rd_data_o == 32'h0000_0000))
    else $error("read data stood without a read");

  // pending bits only drop on a write to the pending register
  AST_PEND_STICKY: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    (st_r.ipend[0] && !(reg_req_i.wr && (a == sqm_pkg::OFS_INT_PEND))) |=> st_r.ipend[0])
    else $error("pending bit dropped without a clear");

endmodule
`default_nettype wire

// file: sim/engine_latch.sv
// partner model: a network engine that latches its own queue's fill flags
`timescale 1ns/100ps
`default_nettype none
module engine_latch #(
  parameter int unsigned QSEL = 0
) (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic reset_i,
  // flag bus from the queue manager
  input wire sqm_pkg::flag_bus_t flag_bus_i,
  // latched status of the watched queue
  output logic [3:0] flags_o
);
  // ==========================================================================
  // latch
  // only the own nibble is taken, so a mix-up of queue lanes shows here
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      flags_o <= 4'h3;
    end else begin
      flags_o <= flag_bus_i[QSEL];
    end
  end
endmodule
`default_nettype wire

// file: sim/tb.sv
// testbench: queue traffic, status and interrupt checks of the queue manager
`timescale 1ns/100ps
`default_nettype none
module tb;
  typedef struct packed {
    logic rd;
    logic [13:0] addr;
    logic [31:0] data;
  } row_s;

  // ==========================================================================
  // signals
  logic ref_clk_i;
  logic reset_i;
  sqm_pkg::reg_req_s reg_req;
  logic [31:0] rd_data;
  sqm_pkg::flag_bus_t flag_bus;
  sqm_pkg::flag_s event_bus;
  logic irq_lo;
  logic irq_hi;
  logic [3:0] eng_flags;
  int err_count = 0;
  int n_tests = 0;
  // fill flags expected after each entry pushed into queue 2
  logic [3:0] fill_exp [8] = '{4'h2, 4'h2, 4'h0, 4'h0, 4'h0, 4'h0, 4'h4, 4'hC};

  // ordinary cases plus underflow and out-of-order access: reads carry the expected data, writes the data sent
  row_s rows [24] = '{
    '{1'b0, 14'h2000, 32'h0400_0000}, '{1'b0, 14'h0000, 32'hA1A1_0001}, '{1'b0, 14'h0000, 32'hA2A2_0002},
    '{1'b1, 14'h2100, 32'hA1A1_0001}, '{1'b1, 14'h0000, 32'hA1A1_0001}, '{1'b1, 14'h0000, 32'hA2A2_0002},
    '{1'b1, 14'h0000, 32'h0}, '{1'b1, 14'h0410, 32'h1}, '{1'b0, 14'h0410, 32'h1},
    '{1'b1, 14'h0410, 32'h0}, '{1'b1, 14'h2000, 32'h0400_0102}, '{1'b1, 14'h0008, 32'h0},
    '{1'b1, 14'h1000, 32'h0}, '{1'b0, 14'h0400, 32'hFFFF_FFFF}, '{1'b1, 14'h0400, 32'h3333_3333},
    '{1'b0, 14'h2004, 32'h0500_4000}, '{1'b0, 14'h0014, 32'hDEAD_0001}, '{1'b1, 14'h2004, 32'h0500_4000},
    '{1'b0, 14'h0010, 32'hC0C0_0000}, '{1'b0, 14'h0014, 32'hC1C1_0001}, '{1'b1, 14'h2004, 32'h0500_4100},
    '{1'b1, 14'h0010, 32'hC0C0_0000}, '{1'b1, 14'h0014, 32'hC1C1_0001}, '{1'b1, 14'h2004, 32'h0500_4102}
  };

  // ==========================================================================
  // design and partner
  sram_queue_manager i_dut (
    .ref_clk_i(ref_clk_i),
    .reset_i(reset_i),
    .reg_req_i(reg_req),
    .rd_data_o(rd_data),
    .flag_bus_o(flag_bus),
    .event_bus_o(event_bus),
    .irq_lo_o(irq_lo),
    .irq_hi_o(irq_hi)
  );
  engine_latch #(.QSEL(0)) i_eng (
    .ref_clk_i(ref_clk_i),
    .reset_i(reset_i),
    .flag_bus_i(flag_bus),
    .flags_o(eng_flags)
  );

  // ==========================================================================
  // tasks
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask

  // one-cycle strobes; the #1 lets the taking edge's updates land
  task automatic wr(input logic [13:0] a, input logic [31:0] d);
    @(posedge ref_clk_i);
    reg_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge ref_clk_i);
    reg_req.wr <= 1'b0;
    #1;
  endtask

  // read data stands only in the cycle after the strobe
  task automatic rd(input logic [13:0] a, input logic [31:0] exp);
    @(posedge ref_clk_i);
    reg_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
    @(posedge ref_clk_i);
    reg_req.rd <= 1'b0;
    #1;
    chk($sformatf("read at %h", a), exp, rd_data);
  endtask

  task automatic final_report;
    $display("%0d checks, %0d mismatches", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // ==========================================================================
  // clock and watchdog
  initial begin
    ref_clk_i = 1'b0;
    forever #2.5 ref_clk_i = ~ref_clk_i;
  end
  // the tests need well under a thousand cycles
  initial begin
    repeat (5000) @(posedge ref_clk_i);
    err_count++;
    final_report();
  end

  // ==========================================================================
  // main sequence
  initial begin
    reset_i = 1'b1;
    reg_req = '0;
    repeat (4) @(posedge ref_clk_i);
    reset_i <= 1'b0;
    @(posedge ref_clk_i);
    #1;
    chk("flag bus", {8{4'h3}}, flag_bus[7:0]);
    chk("event bus", 32'h3, {28'h0, event_bus});
    chk("irqs", 32'h0, {30'h0, irq_hi, irq_lo});
    $display("test reset done");
    // config through raw sram, fifo order, underflow, multi-word entries
    foreach (rows[i]) begin
      if (rows[i].rd) rd(rows[i].addr, rows[i].data);
      else wr(rows[i].addr, rows[i].data);
    end
    $display("test table done");
    // fill to the brim, overflow, then drain across the wrap
    for (int i = 0; i < 16; i++) wr(14'h0000, 32'hB000_0000 + i);
    chk("queue 0 full flag", 32'h1, {31'h0, flag_bus[0].full});
    wr(14'h0000, 32'hEEEE_EEEE);
    rd(14'h0414, 32'h1);
    for (int i = 0; i < 16; i++) rd(14'h0000, 32'hB000_0000 + i);
    rd(14'h2000, 32'h0400_0102);
    $display("test overflow done");
    // pointer bits above the queue size are dropped when the word goes back
    wr(14'h2004, 32'h0500_4912);
    wr(14'h0010, 32'hE0E0_0000);
    wr(14'h0014, 32'hE1E1_0001);
    rd(14'h2004, 32'h0500_4202);
    rd(14'h0010, 32'hE0E0_0000);
    rd(14'h0014, 32'hE1E1_0001);
    // four-word entries in a 32-word queue, watermarks of 2 and 1 entries
    wr(14'h2008, 32'h0729_8000);
    for (int e = 0; e < 8; e++) begin
      for (int k = 0; k < 4; k++) wr(14'h0020 + 14'(4 * k), 32'hD000_0000 + 32'(4 * e + k));
      chk("queue 2 flags", {28'h0, fill_exp[e]}, {28'h0, flag_bus[2]});
    end
    for (int k = 0; k < 4; k++) rd(14'h0020 + 14'(4 * k), 32'hD000_0000 + 32'(k));
    chk("queue 2 flags", 32'h4, {28'h0, flag_bus[2]});
    $display("test entry sizes done");
    // low group interrupt on empty deassertion
    wr(14'h0420, 32'h4);
    wr(14'h0438, 32'hFFFF_FFFF);
    wr(14'h0430, 32'h1);
    chk("irq low idle", 32'h0, {31'h0, irq_lo});
    wr(14'h0000, 32'h5555_0000);
    chk("irq low raised", 32'h1, {31'h0, irq_lo});
    @(posedge ref_clk_i);
    #1 chk("engine latch", 32'h0, {28'h0, eng_flags});
    wr(14'h0430, 32'h0);
    chk("irq low masked", 32'h0, {31'h0, irq_lo});
    rd(14'h0438, 32'h1);
    wr(14'h0438, 32'h1);
    wr(14'h0430, 32'h1);
    rd(14'h0000, 32'h5555_0000);
    chk("irq low after assertion", 32'h0, {31'h0, irq_lo});
    $display("test irq low done");
    // high group interrupt on low-fill rising of queue 32
    wr(14'h2080, 32'h0600_0000);
    wr(14'h043C, 32'hFFFF_FFFF);
    wr(14'h0434, 32'h1);
    wr(14'h0200, 32'h7777_0000);
    rd(14'h0418, 32'hFFFF_FFFE);
    chk("event bus", 32'h3, {28'h0, event_bus});
    chk("irq high idle", 32'h0, {31'h0, irq_hi});
    rd(14'h0200, 32'h7777_0000);
    chk("irq high raised", 32'h1, {31'h0, irq_hi});
    $display("test irq high done");
    // reset in mid-run drops the interrupt and the enables
    @(posedge ref_clk_i);
    reset_i <= 1'b1;
    repeat (4) @(posedge ref_clk_i);
    reset_i <= 1'b0;
    @(posedge ref_clk_i);
    #1 chk("irq after reset", 32'h0, {30'h0, irq_hi, irq_lo});
    rd(14'h0434, 32'h0);
    $display("test second reset done");
    final_report();
  end
endmodule
`default_nettype wire
